// file: core/qdac_regs.svh
/*
 * constants for the quad converter serial load logic: word layout,
 * counts and reset values.
 * assumes to be included by the package and the core file only.
 */
`ifndef QDAC_REGS_SVH
`define QDAC_REGS_SVH

// ----------------------------------------------------------------------
// word layout
// ----------------------------------------------------------------------
`define QDAC_WORD_W     16
`define QDAC_WORD_MSB   15
`define QDAC_CODE_W     12
`define QDAC_ADDR_W     2
`define QDAC_CHAN_W     2
`define QDAC_NUM_CHAN   4

// ----------------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------------
`define QDAC_CNT_W      4
`define QDAC_CNT_ZERO   4'h0
`define QDAC_CNT_ONE    4'h1
`define QDAC_CNT_LAST   4'hf
`define QDAC_CODE_ZERO  12'h000
`define QDAC_SR_ZERO    16'h0000
`define QDAC_FIFO_DEPTH 16

// ----------------------------------------------------------------------
// synchronised pin positions
// ----------------------------------------------------------------------
`define QDAC_PIN_N      7
`define QDAC_PIN_FS     0
`define QDAC_PIN_CLK    1
`define QDAC_PIN_SDI    2
`define QDAC_PIN_ALO    3
`define QDAC_PIN_AHI    4
`define QDAC_PIN_LOAD   5
`define QDAC_PIN_CLR    6
`define QDAC_PIN_IDLE   7'h63

`endif

// file: core/qdac_pkg.sv
/*
 * types of the quad converter serial load logic.
 * assumes qdac_regs.svh is on the include path.
 */
`include "qdac_regs.svh"

package qdac_pkg;

    // ------------------------------------------------------------------
    // received word, msb first on the wire
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`QDAC_CODE_W-1:0] code;
        logic [`QDAC_ADDR_W-1:0] addr;
        logic [`QDAC_CHAN_W-1:0] chan;
    } qdac_word_t;

    // ------------------------------------------------------------------
    // frame state, gray along idle -> shift -> done
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        QDAC_IDLE  = 2'h0,
        QDAC_SHIFT = 2'h1,
        QDAC_DONE  = 2'h3
    } qdac_state_t;

endpackage : qdac_pkg

// file: core/qdac_core.sv
/*
 * serial load logic of a quad 12 bit converter plus its word fifo.
 * assumes all pins are asynchronous to i_core_clk and that the shift
 * clock runs well below a quarter of i_core_clk.
 */
`timescale 1ns/1ns
`include "qdac_regs.svh"

// ----------------------------------------------------------------------
// word fifo
// ----------------------------------------------------------------------
module qdac_fifo
    import qdac_pkg::*;
#(
    parameter int W = `QDAC_WORD_W,
    parameter int D = `QDAC_FIFO_DEPTH
)(
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_ff [D];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    logic [AW:0]  nxt_wp;
    logic [AW:0]  nxt_rp;
    logic         full;
    logic         empty;
    logic         do_wr;
    logic         do_rd;

    always_comb
    begin
        empty  = (wp_ff == rp_ff);
        full   = (wp_ff[AW] != rp_ff[AW]) &&
                 (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
        do_wr  = i_in_valid && !full;
        do_rd  = !empty && i_out_ready;
        nxt_wp = do_wr ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = do_rd ? rp_ff + 1'b1 : rp_ff;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
        if (do_wr)
        begin
            mem_ff[wp_ff[AW-1:0]] <= i_in_data;
        end
    end

    assign o_in_ready  = !full;
    assign o_out_valid = !empty;
    assign o_out_data  = mem_ff[rp_ff[AW-1:0]];
endmodule : qdac_fifo

// ----------------------------------------------------------------------
// serial load top
// ----------------------------------------------------------------------
module qdac_core
    import qdac_pkg::*;
(
    input  wire logic           i_core_clk,
    input  wire logic           i_rst,
    input  wire logic           i_frame_sync_n,
    input  wire logic           i_shift_clock,
    input  wire logic           i_serial_in,
    input  wire logic           i_addr_strap_lo,
    input  wire logic           i_addr_strap_hi,
    input  wire logic           i_load_all_n,
    input  wire logic           i_clear_all_n,
    output logic                o_chain_out,
    output logic [`QDAC_NUM_CHAN-1:0][`QDAC_CODE_W-1:0] o_dac_code,
    output logic                o_overrun
);
    logic [`QDAC_PIN_N-1:0]      pin_raw;
    logic [`QDAC_PIN_N-1:0]      s1_ff;
    logic [`QDAC_PIN_N-1:0]      s2_ff;
    logic                        clk_prev_ff;
    logic                        fall;
    logic                        frame_low;
    qdac_state_t                 state_ff;
    qdac_state_t                 nxt_state;
    logic [`QDAC_CNT_W-1:0]      cnt_ff;
    logic [`QDAC_CNT_W-1:0]      nxt_cnt;
    logic [`QDAC_WORD_W-1:0]     sr_ff;
    logic [`QDAC_WORD_W-1:0]     nxt_sr;
    logic                        push;
    logic                        in_ready;
    logic                        out_valid;
    logic                        out_ready;
    logic [`QDAC_WORD_W-1:0]     out_raw;
    qdac_word_t                  out_word;
    logic                        hit;
    logic                        overrun_ff;
    logic                        nxt_overrun;
    logic [`QDAC_NUM_CHAN-1:0][`QDAC_CODE_W-1:0] in_latch_ff;
    logic [`QDAC_NUM_CHAN-1:0][`QDAC_CODE_W-1:0] nxt_in_latch;
    logic [`QDAC_NUM_CHAN-1:0][`QDAC_CODE_W-1:0] dac_ff;
    logic [`QDAC_NUM_CHAN-1:0][`QDAC_CODE_W-1:0] nxt_dac;

    // ------------------------------------------------------------------
    // pin synchronisers, two flops per pin
    // ------------------------------------------------------------------
    assign pin_raw = {i_clear_all_n, i_load_all_n, i_addr_strap_hi,
                      i_addr_strap_lo, i_serial_in, i_shift_clock,
                      i_frame_sync_n};

    // preload idle levels so no false shift edge follows reset
    localparam logic [`QDAC_PIN_N-1:0] PIN_IDLE = `QDAC_PIN_IDLE;

    genvar g;
    generate
        for (g = 0; g < `QDAC_PIN_N; g++)
        begin : g_sync
            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                begin
                    s1_ff[g] <= PIN_IDLE[g];
                    s2_ff[g] <= PIN_IDLE[g];
                end
                else
                begin
                    s1_ff[g] <= pin_raw[g];
                    s2_ff[g] <= s1_ff[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // frame and shift register
    // ------------------------------------------------------------------
    assign frame_low = !s2_ff[`QDAC_PIN_FS];
    assign fall      = clk_prev_ff && !s2_ff[`QDAC_PIN_CLK];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_sr    = sr_ff;
        push      = 1'b0;
        if (!frame_low)
        begin
            nxt_state = QDAC_IDLE;
            nxt_cnt   = `QDAC_CNT_ZERO;
        end
        else if (fall)
        begin
            // keeps shifting past the 16th edge so chained parts see it
            nxt_sr = {sr_ff[`QDAC_WORD_MSB-1:0], s2_ff[`QDAC_PIN_SDI]};
            unique case (state_ff)
                QDAC_IDLE,
                QDAC_SHIFT:
                begin
                    nxt_cnt   = cnt_ff + `QDAC_CNT_ONE;
                    nxt_state = QDAC_SHIFT;
                    if (cnt_ff == `QDAC_CNT_LAST)
                    begin
                        push      = 1'b1;
                        nxt_state = QDAC_DONE;
                    end
                end
                QDAC_DONE:
                begin
                    nxt_state = QDAC_DONE;
                end
                default:
                begin
                    nxt_state = QDAC_IDLE;
                end
            endcase
        end
        // a full fifo loses the word; flagged, cleared only by reset
        nxt_overrun = overrun_ff || (push && !in_ready);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_ff    <= QDAC_IDLE;
            cnt_ff      <= `QDAC_CNT_ZERO;
            sr_ff       <= `QDAC_SR_ZERO;
            clk_prev_ff <= 1'b1;
            overrun_ff  <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            sr_ff       <= nxt_sr;
            clk_prev_ff <= s2_ff[`QDAC_PIN_CLK];
            overrun_ff  <= nxt_overrun;
        end
    end

    // ------------------------------------------------------------------
    // word fifo between shifter and latches
    // ------------------------------------------------------------------
    qdac_fifo #(
        .W (`QDAC_WORD_W),
        .D (`QDAC_FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (push),
        .i_in_data   (nxt_sr),
        .o_in_ready  (in_ready),
        .o_out_valid (out_valid),
        .o_out_data  (out_raw),
        .i_out_ready (out_ready)
    );

    // ------------------------------------------------------------------
    // address check, latches
    // ------------------------------------------------------------------
    // input latches are frozen while load is low so the copy is stable
    assign out_ready = s2_ff[`QDAC_PIN_LOAD];

    always_comb
    begin
        out_word     = qdac_word_t'(out_raw);
        hit          = out_valid && out_ready &&
                       (out_word.addr == {s2_ff[`QDAC_PIN_AHI],
                                          s2_ff[`QDAC_PIN_ALO]});
        nxt_in_latch = in_latch_ff;
        if (hit)
        begin
            nxt_in_latch[out_word.chan] = out_word.code;
        end
        nxt_dac = dac_ff;
        if (!s2_ff[`QDAC_PIN_CLR])
        begin
            for (int i = 0; i < `QDAC_NUM_CHAN; i++)
            begin
                nxt_dac[i] = `QDAC_CODE_ZERO;
            end
        end
        else if (!s2_ff[`QDAC_PIN_LOAD])
        begin
            nxt_dac = in_latch_ff;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            in_latch_ff <= '0;
            dac_ff      <= '0;
        end
        else
        begin
            in_latch_ff <= nxt_in_latch;
            dac_ff      <= nxt_dac;
        end
    end

    assign o_chain_out = sr_ff[`QDAC_WORD_MSB];
    assign o_dac_code  = dac_ff;
    assign o_overrun   = overrun_ff;
endmodule : qdac_core

// file: test/qdac_core_checker.sv
/* port assertions for qdac_core, bound to every instance.
   assumes the pins are driven as the serial load contract says. */
`timescale 1ns/1ns
module qdac_core_checker
    import qdac_pkg::*;
(
    input wire logic                  i_core_clk,
    input wire logic                  i_rst,
    input wire logic                  i_frame_sync_n,
    input wire logic                  i_shift_clock,
    input wire logic                  i_serial_in,
    input wire logic                  i_addr_strap_lo,
    input wire logic                  i_addr_strap_hi,
    input wire logic                  i_load_all_n,
    input wire logic                  i_clear_all_n,
    input wire logic                  o_chain_out,
    input wire logic [3:0][11:0]      o_dac_code,
    input wire logic                  o_overrun
);
    // ------------------------------------------------
    // cause history, wide enough for sync latency
    // ------------------------------------------------
    logic [6:0] fall_hist_ff, nxt_fall_hist;
    logic [6:0] lvl_hist_ff,  nxt_lvl_hist;
    logic       sclk_ff,      nxt_sclk;
    always_comb
    begin
        nxt_sclk      = i_shift_clock;
        nxt_fall_hist = {fall_hist_ff[5:0], sclk_ff & ~i_shift_clock};
        nxt_lvl_hist  = {lvl_hist_ff[5:0], ~(i_load_all_n & i_clear_all_n)};
    end
    always_ff @(posedge i_core_clk)
    begin
        sclk_ff      <= nxt_sclk;
        fall_hist_ff <= nxt_fall_hist;
        lvl_hist_ff  <= nxt_lvl_hist;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_clear_low;
        !i_clear_all_n [*6];
    endsequence
    sequence s_latch_hold;
        (i_load_all_n && i_clear_all_n) [*6];
    endsequence
    a_reset_clears: assert property (disable iff (1'b0)
        i_rst |=> o_dac_code == '0 && !o_overrun && !o_chain_out)
        else $error("outputs not cleared by reset");
    a_overrun_sticky: assert property (o_overrun |=> o_overrun)
        else $error("overrun flag dropped");
    a_overrun_cause: assert property ($rose(o_overrun) |-> |fall_hist_ff)
        else $error("overrun without a shifted word");
    a_clear_zeroes: assert property (s_clear_low |-> o_dac_code == '0)
        else $error("clear did not zero the codes");
    a_dac_steady: assert property (s_latch_hold |=> $stable(o_dac_code))
        else $error("codes moved with load and clear idle");
    a_dac_cause: assert property ($changed(o_dac_code) |-> |lvl_hist_ff)
        else $error("codes moved without load or clear");
    a_chain_cause: assert property ($changed(o_chain_out) |-> |fall_hist_ff)
        else $error("chain moved without a shift edge");
    a_chain_idle: assert property (
        i_frame_sync_n [*7] |-> $stable(o_chain_out))
        else $error("chain moved outside a frame");
endmodule : qdac_core_checker

bind qdac_core qdac_core_checker chk_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_frame_sync_n(i_frame_sync_n), .i_shift_clock(i_shift_clock),
    .i_serial_in(i_serial_in), .i_addr_strap_lo(i_addr_strap_lo),
    .i_addr_strap_hi(i_addr_strap_hi), .i_load_all_n(i_load_all_n),
    .i_clear_all_n(i_clear_all_n), .o_chain_out(o_chain_out),
    .o_dac_code(o_dac_code), .o_overrun(o_overrun));

// file: test/qdac_host.sv
/* host model: frames one 16 bit word onto the serial pins per i_go.
   assumes the caller waits for o_busy low between words. */
`timescale 1ns/1ns
module qdac_host
(
    input  wire logic        i_go,
    input  wire logic        i_slow,
    input  wire logic [15:0] i_word,
    output logic             o_frame_sync_n,
    output logic             o_shift_clock,
    output logic             o_serial_in,
    output logic             o_busy
);
    int half;
    initial
    begin
        o_frame_sync_n = 1'b1;
        o_shift_clock  = 1'b1;
        o_serial_in    = 1'b0;
        o_busy         = 1'b0;
    end
    // clock stands high between frames; offset keeps it off core phase
    always @(posedge i_go)
    begin
        o_busy = 1'b1;
        // link period stays 80 ns; slow only stretches the frame lead
        half = 40;
        #3 o_frame_sync_n = 1'b0;
        if (i_slow)
        begin
            #80;
        end
        for (int i = 15; i >= 0; i--)
        begin
            o_serial_in = i_word[i];
            #half o_shift_clock = 1'b0;
            #half o_shift_clock = 1'b1;
        end
        #half o_frame_sync_n = 1'b1;
        // released line shows no stale bit
        o_serial_in = ~o_serial_in;
        o_busy = 1'b0;
    end
endmodule : qdac_host

// file: test/qdac_core_bench.sv
/* self checking bench for qdac_core with a host model.
   assumes qdac_pkg and the checker are compiled first. */
`timescale 1ns/1ns
`define CHK(n, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("mismatch %s exp %h got %h", n, e, g); \
        end \
    end
module qdac_core_bench
    import qdac_pkg::*;
();
    logic             clk, rst, go, slow, busy, load_n, clr_n;
    logic             frame_n, sclk, sdi, chain, overrun;
    logic [1:0]       addr;
    logic [15:0]      word;
    logic [3:0][11:0] dac_code, exp_in, held;
    int               comparisons, miscompares;
    qdac_core dut_u (.i_core_clk(clk), .i_rst(rst),
        .i_frame_sync_n(frame_n), .i_shift_clock(sclk), .i_serial_in(sdi),
        .i_addr_strap_lo(addr[0]), .i_addr_strap_hi(addr[1]),
        .i_load_all_n(load_n), .i_clear_all_n(clr_n),
        .o_chain_out(chain), .o_dac_code(dac_code), .o_overrun(overrun));
    qdac_host host_u (.i_go(go), .i_slow(slow), .i_word(word),
        .o_frame_sync_n(frame_n), .o_shift_clock(sclk),
        .o_serial_in(sdi), .o_busy(busy));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    function automatic logic [3:0][11:0] next_latch(
        input logic [3:0][11:0] cur,
        input logic [15:0]      w,
        input logic [1:0]       strap);
        qdac_word_t wd;
        wd = w;
        next_latch = cur;
        if (wd.addr == strap)
        begin
            next_latch[wd.chan] = wd.code;
        end
    endfunction : next_latch
    task automatic send(input logic [15:0] w, input bit keep);
        int         n;
        @(posedge clk);
        word <= w;
        slow <= ($urandom_range(3) == 0);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000)
        begin
            miscompares++;
            finish_test();
        end
        repeat (8) @(posedge clk);
        `CHK("chain", w[15], chain)
        if (keep)
            exp_in = next_latch(exp_in, w, addr);
    endtask : send
    task automatic load_pulse;
        repeat (40) @(posedge clk);
        load_n <= 1'b0;
        repeat (8) @(posedge clk);
        load_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("dac", exp_in, dac_code)
    endtask : load_pulse
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        {rst, load_n, clr_n} = 3'h7;
        {go, slow, word, exp_in} = '0;
        comparisons = 0;
        miscompares = 0;
        void'($urandom(91));
        addr = 2'($urandom);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("reset", 50'h0, {overrun, chain, dac_code})
        for (int c = 0; c < 4; c++)
            send({12'($urandom), addr, 2'(c)}, 1'b1);
        load_pulse();
        send({12'hfff, ~addr, 2'h0}, 1'b1);
        load_pulse();
        repeat (12)
        begin
            send({12'($urandom), ($urandom_range(1) ? addr : 2'($urandom)),
                  2'($urandom)}, 1'b1);
            load_pulse();
        end
        load_n <= 1'b0;
        clr_n <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("clear", 48'h0, dac_code)
        clr_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("restore", exp_in, dac_code)
        held = exp_in;
        // unequal strap bits catch a hi/lo swap; fifo is empty here
        addr <= 2'h1;
        @(posedge clk);
        // load held low stalls the drain, so the fifo fills
        for (int k = 0; k < 17; k++)
        begin
            send({12'($urandom), addr, 2'($urandom)}, k < 16);
            if (k == 15)
                `CHK("no_overrun", 1'b0, overrun)
        end
        `CHK("overrun", 1'b1, overrun)
        `CHK("frozen", held, dac_code)
        load_n <= 1'b1;
        load_pulse();
        finish_test();
    end
endmodule : qdac_core_bench
